// File: inc/fsc_pkg.sv
// Shared constants and types of the fieldbus slave communication control
package fsc_pkg;

  // ------------------------------------------------------------
  // Parameter indices, reset values and limits
  // ------------------------------------------------------------
  localparam logic [15:0] FSC_IDX_STATION_VALUE = 16'h2023;
  localparam logic [15:0] FSC_IDX_STATION_SOURCE = 16'h2024;
  localparam logic [15:0] FSC_STATION_VALUE_RST = 16'h0002;
  localparam logic [15:0] FSC_STATION_SOURCE_RST = 16'h0001;
  localparam logic [15:0] FSC_STATION_VALUE_MAX = 16'h7fff;
  localparam logic [15:0] FSC_STATION_SOURCE_MAX = 16'h0001;

  // ------------------------------------------------------------
  // Frame layout: byte positions within a frame
  // ------------------------------------------------------------
  localparam logic [7:0] FSC_POS_ADDR_HI = 8'h00;
  localparam logic [7:0] FSC_POS_ADDR_LO = 8'h01;
  localparam logic [7:0] FSC_POS_CMD = 8'h02;
  localparam logic [7:0] FSC_POS_P0 = 8'h03;
  localparam logic [7:0] FSC_POS_P1 = 8'h04;
  localparam logic [7:0] FSC_POS_P2 = 8'h05;
  localparam logic [7:0] FSC_POS_P3 = 8'h06;
  localparam logic [7:0] FSC_POS_P4 = 8'h07;
  localparam logic [7:0] FSC_POS_MAX = 8'hff;

  // ------------------------------------------------------------
  // Frame commands, state codes and status bits
  // ------------------------------------------------------------
  localparam logic [7:0] FSC_CMD_STATE = 8'h01;
  localparam logic [7:0] FSC_CMD_MBX = 8'h02;
  localparam logic [7:0] FSC_CMD_PDO = 8'h03;
  localparam logic [7:0] FSC_CMD_ASSIGN = 8'h04;
  localparam logic [7:0] FSC_CODE_INIT = 8'h01;
  localparam logic [7:0] FSC_CODE_PREOP = 8'h02;
  localparam logic [7:0] FSC_CODE_SAFEOP = 8'h04;
  localparam logic [7:0] FSC_CODE_OP = 8'h08;
  localparam logic [7:0] FSC_STATUS_ERR = 8'h10;
  localparam logic [7:0] FSC_MBX_OP_WRITE = 8'h01;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int FSC_FIFO_WIDTH = 8;
  localparam int FSC_FIFO_DEPTH = 8;
  localparam int FSC_PDO_BYTES = 4;

  typedef enum logic [1:0] {FSC_INIT, FSC_PREOP, FSC_SAFEOP, FSC_OP}
    fsc_state_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } fsc_beat_t;

endpackage : fsc_pkg

// File: hw/fsc_fifo.sv
// Outgoing process data FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module fsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic inValid, // Producer offers a word
  input wire logic [WIDTH-1:0] inData, // Producer word
  output logic inReady, // Room for a word
  output logic outValid, // A word is waiting
  output logic [WIDTH-1:0] outData, // Oldest word
  input wire logic outReady // Consumer takes the word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
    end
    else
    begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      count <= next_count;
      // Registered so the producer never sees a combinational full
      inReady <= (next_count < (AW+1)'(DEPTH));
    end

  always_ff @(posedge mclk)
    if (push) mem[wrPtr] <= inData;
endmodule : fsc_fifo
`default_nettype wire

// File: hw/fsc_comm_ctrl.sv
// Communication-side control of a fieldbus slave node
// Notes on behaviour
// - Only the master originates frames; this node just forwards received ones.
// - Own data is read from and inserted into a passing frame, byte by byte.
// - Forwarding adds only one register stage of delay.
// - With the downstream port open the frame returns toward the master.
// - Identifier source 0 or 1, default 1; 0 master assigns; after restart.
// - Stored identifier defaults to 2, used when source is 1, after restart.
// - Free-running mode applies received process data at once, no sync.
// - Distributed-clock mode captures data on arrival, applies it on sync.
// - Decoding finishes before sync; data is latched at frame end.
// - On sync the prepared output is applied at the next clock edge.
// - Upward changes go one step at a time; skips are refused.
// - Downward changes may jump straight to any lower state.
// - A refused transition is reported back to the master as error.
// - Init blocks mailbox and process data.
// - Pre-operational serves mailbox, no process data.
// - Safe-operational serves mailbox and sends outgoing data, ignores incoming.
// - Operational serves mailbox and exchanges process data both ways.
`timescale 1ns/1ns
`default_nettype none
module fsc_comm_ctrl (
  input wire logic mclk, // 10 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic restart, // Soft restart pulse, reloads identifier
  input wire logic dcMode, // 1 distributed clock, 0 free running
  input wire logic sync0, // Sync event pulse
  input wire logic linkOpen, // Downstream port has no link
  input wire fsc_pkg::fsc_beat_t upRx, // Frame from the master side
  output fsc_pkg::fsc_beat_t dnTx, // Frame toward downstream
  input wire fsc_pkg::fsc_beat_t dnRx, // Returning frame from downstream
  output fsc_pkg::fsc_beat_t upTx, // Frame back toward the master
  input wire logic txpdoValid, // Application offers outgoing byte
  input wire logic [7:0] txpdoData, // Outgoing process data byte
  output logic txpdoReady, // Outgoing buffer has room
  output logic [31:0] pdoOut, // Applied incoming process data
  output logic pdoApply, // Pulse when pdoOut updates
  output fsc_pkg::fsc_state_t commState, // Communication state
  output logic alError, // Last transition was refused
  output logic [15:0] stationAddr // Node address in use
);
  import fsc_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] stateCode(input fsc_state_t s);
    unique case (s)
      FSC_INIT: stateCode = FSC_CODE_INIT;
      FSC_PREOP: stateCode = FSC_CODE_PREOP;
      FSC_SAFEOP: stateCode = FSC_CODE_SAFEOP;
      FSC_OP: stateCode = FSC_CODE_OP;
    endcase
  endfunction : stateCode

  function automatic logic isPayload(input logic [7:0] p, input int n);
    isPayload = (p >= FSC_POS_P0) && (p < FSC_POS_P0 + 8'(n));
  endfunction : isPayload

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [15:0] station_identifier_value;
  logic [15:0] station_identifier_source;
  logic activeSource;
  logic [7:0] pos;
  logic [7:0] addrHi;
  logic hit;
  logic [7:0] cmd;
  logic [7:0] idxHi;
  logic [15:0] mbxIdx;
  logic [7:0] mbxOp;
  logic [7:0] valHi;
  logic [7:0] rxBuf [FSC_PDO_BYTES];
  logic rxPending;

  // ------------------------------------------------------------
  // Frame position and addressing
  // ------------------------------------------------------------
  wire [7:0] curPos = upRx.sof ? FSC_POS_ADDR_HI : pos;
  wire [7:0] next_pos = (curPos == FSC_POS_MAX) ? curPos : curPos + 8'h01;
  wire atAddrLo = upRx.valid && curPos == FSC_POS_ADDR_LO;
  wire addrMatch = ({addrHi, upRx.data} == stationAddr);
  wire inBody = upRx.valid && hit && curPos >= FSC_POS_P0;
  wire mbxOk = (commState != FSC_INIT);
  wire rxOk = (commState == FSC_OP);
  wire txOk = (commState == FSC_SAFEOP) || (commState == FSC_OP);
  wire isState = inBody && cmd == FSC_CMD_STATE;
  wire isMbx = inBody && cmd == FSC_CMD_MBX && mbxOk;
  wire isPdo = inBody && cmd == FSC_CMD_PDO;
  // Broadcast address assignment, honoured only with source 0
  wire isAssign = upRx.valid && cmd == FSC_CMD_ASSIGN && !activeSource;

  // ------------------------------------------------------------
  // State requests
  // ------------------------------------------------------------
  logic reqValid;
  fsc_state_t reqState;
  always_comb
  begin
    reqValid = 1'b1;
    reqState = commState;
    unique case (upRx.data)
      FSC_CODE_INIT: reqState = FSC_INIT;
      FSC_CODE_PREOP: reqState = FSC_PREOP;
      FSC_CODE_SAFEOP: reqState = FSC_SAFEOP;
      FSC_CODE_OP: reqState = FSC_OP;
      default: reqValid = 1'b0;
    endcase
  end
  wire [2:0] stepUp = {1'b0, commState} + 3'h1;
  wire reqOk = reqValid &&
    (reqState <= commState || {1'b0, reqState} == stepUp);
  wire takeReq = isState && curPos == FSC_POS_P0;

  // ------------------------------------------------------------
  // Mailbox parameter access
  // ------------------------------------------------------------
  wire mbxWrite = isMbx && curPos == FSC_POS_P4 && mbxOp == FSC_MBX_OP_WRITE;
  wire [15:0] wrVal = {valHi, upRx.data};
  // Out-of-range writes leave the stored value as it was
  wire wrValue = mbxWrite && mbxIdx == FSC_IDX_STATION_VALUE &&
    wrVal <= FSC_STATION_VALUE_MAX;
  wire wrSource = mbxWrite && mbxIdx == FSC_IDX_STATION_SOURCE &&
    wrVal <= FSC_STATION_SOURCE_MAX;
  wire [15:0] rdVal = (mbxIdx == FSC_IDX_STATION_VALUE) ?
    station_identifier_value :
    (mbxIdx == FSC_IDX_STATION_SOURCE) ? station_identifier_source : 16'h0000;
  wire mbxRead = isMbx && mbxOp != FSC_MBX_OP_WRITE;

  // ------------------------------------------------------------
  // Process data insertion and capture
  // ------------------------------------------------------------
  logic fifoValid;
  logic [7:0] fifoData;
  wire pdoByte = isPdo && isPayload(curPos, FSC_PDO_BYTES);
  wire [1:0] pdoIdx = 2'(curPos - FSC_POS_P0);
  // Empty buffer: the byte passes as received, the frame never waits
  wire txTake = pdoByte && txOk && fifoValid;
  wire rxTake = pdoByte && rxOk;
  wire rxDone = isPdo && rxOk && upRx.eof;
  // Held data is dropped, not applied, once the node leaves Operational
  wire applyNow = dcMode ? (sync0 && rxPending && rxOk) : rxDone;
  wire [31:0] rxWord = {rxBuf[3], rxBuf[2], rxBuf[1], rxBuf[0]};

  fsc_fifo #(
    .WIDTH(FSC_FIFO_WIDTH),
    .DEPTH(FSC_FIFO_DEPTH)
  ) u_txpdo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(txpdoValid),
    .inData(txpdoData),
    .inReady(txpdoReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(txTake)
  );

  // ------------------------------------------------------------
  // Outgoing byte selection
  // ------------------------------------------------------------
  logic [7:0] outData;
  always_comb
  begin
    outData = upRx.data;
    if (isState && curPos == FSC_POS_P1)
      outData = stateCode(commState) | (alError ? FSC_STATUS_ERR : 8'h00);
    else if (mbxRead && curPos == FSC_POS_P3)
      outData = rdVal[15:8];
    else if (mbxRead && curPos == FSC_POS_P4)
      outData = rdVal[7:0];
    else if (txTake)
      outData = fifoData;
  end
  // Never a fresh frame: only the received beat, possibly edited
  wire fsc_beat_t next_fwd = '{valid: upRx.valid, sof: upRx.sof,
    eof: upRx.eof, data: outData};

  // ------------------------------------------------------------
  // Frame tracking registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      pos <= FSC_POS_ADDR_HI;
      addrHi <= 8'h00;
      hit <= 1'b0;
      cmd <= 8'h00;
      idxHi <= 8'h00;
      mbxIdx <= 16'h0000;
      mbxOp <= 8'h00;
      valHi <= 8'h00;
    end
    else if (upRx.valid)
    begin
      pos <= next_pos;
      if (curPos == FSC_POS_ADDR_HI) addrHi <= upRx.data;
      if (curPos == FSC_POS_ADDR_HI) hit <= 1'b0;
      if (atAddrLo) hit <= addrMatch;
      if (curPos == FSC_POS_CMD) cmd <= upRx.data;
      if (curPos == FSC_POS_P0) idxHi <= upRx.data;
      if (curPos == FSC_POS_P1) mbxIdx <= {idxHi, upRx.data};
      if (curPos == FSC_POS_P2) mbxOp <= upRx.data;
      if (curPos == FSC_POS_P3) valHi <= upRx.data;
    end

  // ------------------------------------------------------------
  // Communication state machine
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      commState <= FSC_INIT;
      alError <= 1'b0;
    end
    else if (takeReq)
    begin
      // A same-state request is accepted and clears the error
      if (reqOk) commState <= reqState;
      alError <= !reqOk;
    end

  // ------------------------------------------------------------
  // Identifier parameters, applied only on restart
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      station_identifier_value <= FSC_STATION_VALUE_RST;
      station_identifier_source <= FSC_STATION_SOURCE_RST;
    end
    else
    begin
      if (wrValue) station_identifier_value <= wrVal;
      if (wrSource) station_identifier_source <= wrVal;
    end

  // Stored settings reach the address only here, hence after restart
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      activeSource <= FSC_STATION_SOURCE_RST[0];
      stationAddr <= FSC_STATION_VALUE_RST;
    end
    else if (restart)
    begin
      activeSource <= station_identifier_source[0];
      if (station_identifier_source[0])
        stationAddr <= station_identifier_value;
    end
    else if (isAssign && curPos == FSC_POS_P1)
      stationAddr <= {idxHi, upRx.data};

  // ------------------------------------------------------------
  // Incoming process data: capture, then apply
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < FSC_PDO_BYTES; i++) rxBuf[i] <= 8'h00;
    else if (rxTake)
      rxBuf[pdoIdx] <= upRx.data;

  // A frame finishing with the sync keeps its data pending
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rxPending <= 1'b0;
    else if (rxDone && dcMode)
      rxPending <= 1'b1;
    else if (applyNow || !rxOk)
      rxPending <= 1'b0;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      pdoOut <= 32'h0000_0000;
      pdoApply <= 1'b0;
    end
    else
    begin
      pdoApply <= applyNow;
      if (applyNow)
        pdoOut <= rxWord;
    end

  // ------------------------------------------------------------
  // Forwarding: one stage, downstream or turned back
  // ------------------------------------------------------------
  // No store and forward: one register stage is the whole latency
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      dnTx <= '0;
      upTx <= '0;
    end
    else
    begin
      dnTx <= linkOpen ? '0 : next_fwd;
      upTx <= linkOpen ? next_fwd : dnRx;
    end

endmodule : fsc_comm_ctrl
`default_nettype wire

// File: verif/fsc_comm_ctrl_props.sv
// Port-level assertions of the communication control block
`timescale 1ns/1ns
`default_nettype none
module fsc_comm_ctrl_props (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic restart, // Soft restart
  input wire logic dcMode, // Sync mode
  input wire logic sync0, // Sync event
  input wire logic linkOpen, // Last node
  input wire fsc_pkg::fsc_beat_t upRx, // From master side
  input wire fsc_pkg::fsc_beat_t dnTx, // Downstream out
  input wire fsc_pkg::fsc_beat_t dnRx, // Returning in
  input wire fsc_pkg::fsc_beat_t upTx, // Toward master
  input wire logic [31:0] pdoOut, // Applied data
  input wire logic pdoApply, // Apply pulse
  input wire fsc_pkg::fsc_state_t commState, // State
  input wire logic [15:0] stationAddr // Address
);
  import fsc_pkg::*;
  // ------------------------------------------------------------
  // Forwarding, state, data apply and address checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_dn_fwd;
    upRx.valid && !linkOpen |=> dnTx.valid && dnTx.sof == $past(upRx.sof)
      && dnTx.eof == $past(upRx.eof);
  endproperty
  a_dn_fwd: assert property (p_dn_fwd)
    else $error("byte not forwarded one cycle later");
  property p_no_orig;
    dnTx.valid |-> $past(upRx.valid);
  endproperty
  a_no_orig: assert property (p_no_orig)
    else $error("node sent a byte it never received");
  property p_ret;
    upRx.valid && linkOpen |=> upTx.valid && !dnTx.valid;
  endproperty
  a_ret: assert property (p_ret)
    else $error("frame not turned back at open port");
  property p_pass;
    dnRx.valid && !linkOpen |=> upTx == $past(dnRx);
  endproperty
  a_pass: assert property (p_pass)
    else $error("returning byte not passed upward");
  property p_step;
    commState > $past(commState) |-> commState == $past(commState) + 2'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("upward state skip");
  property p_state_src;
    commState != $past(commState) |-> $past(upRx.valid);
  endproperty
  a_state_src: assert property (p_state_src)
    else $error("state changed without a request");
  property p_apply_src;
    pdoOut != $past(pdoOut) |-> pdoApply;
  endproperty
  a_apply_src: assert property (p_apply_src)
    else $error("output data changed without apply");
  property p_dc;
    dcMode && $past(dcMode) && pdoApply |-> $past(sync0);
  endproperty
  a_dc: assert property (p_dc)
    else $error("sync mode apply not on sync event");
  property p_free;
    !dcMode && !$past(dcMode) && pdoApply |-> $past(upRx.eof) && $past(upRx.valid);
  endproperty
  a_free: assert property (p_free)
    else $error("free run apply not after frame end");
  property p_op;
    pdoApply |-> commState == FSC_OP;
  endproperty
  a_op: assert property (p_op)
    else $error("incoming data applied outside operational");
  property p_addr;
    stationAddr != $past(stationAddr) |-> $past(restart) || $past(upRx.valid);
  endproperty
  a_addr: assert property (p_addr)
    else $error("address changed without restart or assign");
endmodule : fsc_comm_ctrl_props
bind fsc_comm_ctrl fsc_comm_ctrl_props u_props (.mclk(mclk), .rst_n(rst_n),
  .restart(restart), .dcMode(dcMode), .sync0(sync0), .linkOpen(linkOpen),
  .upRx(upRx), .dnTx(dnTx), .dnRx(dnRx), .upTx(upTx), .pdoOut(pdoOut),
  .pdoApply(pdoApply), .commState(commState), .stationAddr(stationAddr));
`default_nettype wire

// File: verif/fsc_master_model.sv
// Behavioural network master that sends frames and records the echo
`timescale 1ns/1ns
`default_nettype none
module fsc_master_model (
  input wire logic mclk, // Clock
  input wire logic linkOpen, // Echo comes back upward when set
  output fsc_pkg::fsc_beat_t upRx, // Frame toward the node
  input wire fsc_pkg::fsc_beat_t dnTx, // Node downstream output
  input wire fsc_pkg::fsc_beat_t upTx // Node upward output
);
  import fsc_pkg::*;
  logic [63:0] echo;
  initial upRx = '0;
  // Only this model starts frames; eight bytes, hi byte first
  task automatic sendFrame(input logic [63:0] f);
    fsc_beat_t o;
    for (int i = 0; i <= 8; i++)
    begin
      @(negedge mclk);
      o = linkOpen ? upTx : dnTx;
      if (i > 0) echo[71-8*i -: 8] = o.data;
      // Idle line shows a changing pattern, not the last byte
      if (i < 8) upRx = '{1'b1, i == 0, i == 7, f[63-8*i -: 8]};
      else upRx = '{1'b0, 1'b0, 1'b0, ~upRx.data};
    end
  endtask : sendFrame
endmodule : fsc_master_model
`default_nettype wire

// File: verif/test_fieldbus_slave_comm_control.sv
// Self-checking bench of the communication control block
`timescale 1ns/1ns
`default_nettype none
module test_fieldbus_slave_comm_control;
  import fsc_pkg::*;
  logic mclk, rst_n, restart, dcMode, sync0, linkOpen;
  logic txpdoValid, txpdoReady, pdoApply, alError;
  logic [7:0] txpdoData;
  logic [31:0] pdoOut;
  logic [15:0] stationAddr;
  fsc_beat_t upRx, dnTx, dnRx, upTx;
  fsc_state_t commState;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int pushed;
  // Rows: {request, state, status byte}
  logic [17:0] rows [7] = '{18'h02011, 18'h00902, 18'h02112, 18'h01204,
    18'h02308, 18'h00401, 18'h00c11};
  fsc_comm_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .restart(restart),
    .dcMode(dcMode), .sync0(sync0), .linkOpen(linkOpen), .upRx(upRx),
    .dnTx(dnTx), .dnRx(dnRx), .upTx(upTx), .txpdoValid(txpdoValid),
    .txpdoData(txpdoData), .txpdoReady(txpdoReady), .pdoOut(pdoOut),
    .pdoApply(pdoApply), .commState(commState), .alError(alError),
    .stationAddr(stationAddr));
  fsc_master_model u_master (.mclk(mclk), .linkOpen(linkOpen), .upRx(upRx),
    .dnTx(dnTx), .upTx(upTx));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic req(input logic [15:0] a, input logic [7:0] c,
    input logic [39:0] p);
    u_master.sendFrame({a, c, p});
  endtask : req
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    restart = 1'b0;
    dcMode = 1'b0;
    sync0 = 1'b0;
    linkOpen = 1'b0;
    txpdoValid = 1'b0;
    txpdoData = 8'h00;
    dnRx = '0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    chk("state", commState, FSC_INIT);
    chk("addr", stationAddr, 16'h0002);
    req(16'h0002, FSC_CMD_MBX, {16'h2023, 8'h00, 16'h5a5a});
    chk("mbxInit", u_master.echo[15:0], 16'h5a5a);
    for (int i = 0; i < 7; i++)
    begin
      linkOpen = i[0];
      req(16'h0002, FSC_CMD_STATE, {rows[i][17:10], 32'h0});
      chk("state", commState, rows[i][9:8]);
      chk("error", alError, rows[i][4]);
      chk("status", u_master.echo[31:24], rows[i][7:0]);
    end
    @(negedge mclk);
    dnRx = '{1'b1, 1'b1, 1'b1, 8'h3c};
    @(negedge mclk);
    dnRx = '{1'b0, 1'b0, 1'b0, 8'hc3};
    chk("return", upTx, {1'b1, 1'b1, 1'b1, 8'h3c});
    req(16'h0002, FSC_CMD_STATE, {8'h02, 32'h0});
    req(16'h0002, FSC_CMD_MBX, {16'h2023, 8'h00, 16'h0000});
    chk("mbxRead", u_master.echo[15:0], 16'h0002);
    req(16'h0002, FSC_CMD_MBX, {16'h2024, 8'h01, 16'h0000});
    pulse(restart);
    req(16'h1234, FSC_CMD_ASSIGN, {16'h0005, 24'h0});
    chk("assign", stationAddr, 16'h0005);
    req(16'h0005, FSC_CMD_MBX, {16'h2023, 8'h01, 16'h0007});
    req(16'h0005, FSC_CMD_MBX, {16'h2024, 8'h01, 16'h0001});
    chk("noRestart", stationAddr, 16'h0005);
    pulse(restart);
    chk("stored", stationAddr, 16'h0007);
    req(16'h0007, FSC_CMD_MBX, {16'h2024, 8'h01, 16'h0002});
    req(16'h0007, FSC_CMD_MBX, {16'h2024, 8'h00, 16'h0000});
    chk("srcRange", u_master.echo[15:0], 16'h0001);
    req(16'h0007, FSC_CMD_MBX, {16'h2023, 8'h01, 16'h8000});
    req(16'h0007, FSC_CMD_MBX, {16'h2023, 8'h00, 16'h0000});
    chk("valRange", u_master.echo[15:0], 16'h0007);
    req(16'h0007, FSC_CMD_STATE, {8'h04, 32'h0});
    txpdoValid = 1'b1;
    pushed = 0;
    while (txpdoReady === 1'b1 && pushed < 12)
    begin
      txpdoData = 8'hd0 + 8'(pushed);
      @(negedge mclk);
      pushed++;
    end
    txpdoValid = 1'b0;
    chk("fill", pushed, 8);
    req(16'h0007, FSC_CMD_PDO, {32'ha1a2a3a4, 8'h00});
    chk("txSafe", u_master.echo[39:8], 32'hd0d1d2d3);
    chk("ready", txpdoReady, 1'b1);
    chk("rxIgnored", pdoOut, 32'h0);
    req(16'h0007, FSC_CMD_STATE, {8'h08, 32'h0});
    req(16'h0007, FSC_CMD_PDO, {32'hb1b2b3b4, 8'h00});
    chk("txOp", u_master.echo[39:8], 32'hd4d5d6d7);
    chk("freeRun", pdoOut, 32'hb4b3b2b1);
    chk("applyFree", pdoApply, 1'b1);
    dcMode = 1'b1;
    req(16'h0007, FSC_CMD_PDO, {32'hc1c2c3c4, 8'h00});
    chk("empty", u_master.echo[39:8], 32'hc1c2c3c4);
    chk("held", pdoOut, 32'hb4b3b2b1);
    // Data already delivered before the sync event
    pulse(sync0);
    chk("sync", pdoOut, 32'hc4c3c2c1);
    chk("apply", pdoApply, 1'b1);
    @(negedge mclk);
    chk("applyEnd", pdoApply, 1'b0);
    // Pending data must not act once the node has dropped to Safe-Op
    req(16'h0007, FSC_CMD_PDO, {32'he1e2e3e4, 8'h00});
    req(16'h0007, FSC_CMD_STATE, {8'h04, 32'h0});
    chk("down", commState, FSC_SAFEOP);
    pulse(sync0);
    chk("dropped", pdoOut, 32'hc4c3c2c1);
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    chk("reState", commState, FSC_INIT);
    chk("reAddr", stationAddr, 16'h0002);
    rst_n = 1'b1;
    @(negedge mclk);
    test_done();
  end
endmodule : test_fieldbus_slave_comm_control
`default_nettype wire
